// [core/ccp_pkg.sv]
// Package of register map, field layout, mode codes and carrier types for the CCP unit
package ccp_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] CCP_OFF_CTRL   = 3'h0;
    localparam logic [2:0] CCP_OFF_VAL_LO = 3'h1;
    localparam logic [2:0] CCP_OFF_VAL_HI = 3'h2;
    localparam logic [2:0] CCP_OFF_CAPSEL = 3'h3;
    localparam logic [2:0] CCP_OFF_TBSEL  = 3'h4;
    localparam logic [2:0] CCP_OFF_STATUS = 3'h5;

    // Field positions in the module control and status registers
    localparam int CCP_CTRL_EN_BIT  = 7;
    localparam int CCP_CTRL_OE_BIT  = 6;
    localparam int CCP_CTRL_OUT_BIT = 5;
    localparam int CCP_CTRL_FMT_BIT = 4;
    localparam int CCP_STAT_FLAG_BIT = 0;

    // Values after reset
    localparam logic [7:0] CCP_CTRL_RST   = 8'h00;
    localparam logic [7:0] CCP_VAL_RST    = 8'h00;
    localparam logic [2:0] CCP_CAPSEL_RST = 3'h0;
    localparam logic [1:0] CCP_TBSEL_RST  = 2'h0;
    localparam logic [9:0] CCP_DUTY_RST   = 10'h000;
    localparam logic [3:0] CCP_PSC_RST    = 4'h0;

    // Mode field codes
    localparam logic [3:0] CCP_M_OFF        = 4'h0;
    localparam logic [3:0] CCP_M_TOG_CLR    = 4'h1;
    localparam logic [3:0] CCP_M_TOG        = 4'h2;
    localparam logic [3:0] CCP_M_CAP_EDGE   = 4'h3;
    localparam logic [3:0] CCP_M_CAP_FALL   = 4'h4;
    localparam logic [3:0] CCP_M_CAP_RISE   = 4'h5;
    localparam logic [3:0] CCP_M_CAP_RISE4  = 4'h6;
    localparam logic [3:0] CCP_M_CAP_RISE16 = 4'h7;
    localparam logic [3:0] CCP_M_SET        = 4'h8;
    localparam logic [3:0] CCP_M_CLR        = 4'h9;
    localparam logic [3:0] CCP_M_FLAG       = 4'hA;
    localparam logic [3:0] CCP_M_PULSE_CLR  = 4'hB;
    localparam logic [1:0] CCP_M_PWM_TOP    = 2'h3;

    // Capture source select codes
    localparam logic [2:0] CCP_SRC_PIN  = 3'h0;
    localparam logic [2:0] CCP_SRC_CMP1 = 3'h1;
    localparam logic [2:0] CCP_SRC_CMP2 = 3'h2;
    localparam logic [2:0] CCP_SRC_IOC  = 3'h3;
    localparam logic [2:0] CCP_SRC_LC1  = 3'h4;
    localparam logic [2:0] CCP_SRC_LC2  = 3'h5;

    // Prescaler terminal counts for every 4th and 16th rising edge
    localparam logic [3:0] CCP_PSC_LAST4  = 4'h3;
    localparam logic [3:0] CCP_PSC_LAST16 = 4'hF;

    // One period timer as seen by the unit
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] limit;
        logic [1:0] low_bits;
        logic       inc;
    } ccp_tb_type;

    // Capture trigger sources from on-chip logic
    typedef struct packed {
        logic cmp_one_synced;
        logic cmp_two_synced;
        logic pin_change_trigger;
        logic logic_cell_one_out;
        logic logic_cell_two_out;
    } ccp_src_type;

endpackage

// [core/ccp_unit.sv]
// Capture, compare and PWM unit with its register port and pin drive
//
// Summary of operation
// - Capture source chosen by 3-bit select field.
// - Prescaler cleared when disabled, not capturing, reset.
// - Prescaler change alone does not clear counter.
// - Each capture gives one-clock output pulse.
// - Capture drives pin only if pin not input.
// - Capture works in Sleep with external timer.
// - Mode change may set flag; software clears.
// - Compare value pair against sixteen-bit count.
// - Match performs mode action and sets flag.
// - Flag-only compare mode leaves pin alone.
// - Pulse modes output high while equal.
// - Toggle modes invert output on each match.
// - Clear mode drives low, set mode high.
// - Compare need not run during Sleep.
// - PWM time base is period count plus low bits.
// - Duty bit placement follows alignment select.
// - Zero control register releases the pin.
// - Timebase select picks one of NUM_TB timers, three by default.
// - Capture copies count, sets flag, overwrites older.
// - Capture on edge, fall, rise, 4th, 16th rise.
// - Period restart sets output if duty nonzero, latches buffered duty.
// - PWM output low when time base equals duty.
`timescale 1ns/1ns

module ccp_unit
    import ccp_pkg::*;
#(
    parameter int NUM_TB = 3
) (
    input  wire logic                    i_clock,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_clk_en,
    input  wire logic [2:0]              i_addr,
    input  wire logic [7:0]              i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic      [7:0]              o_rdata,
    input  wire logic                    i_sleep,
    input  wire logic                    i_pin,
    output logic                         o_pin_out,
    output logic                         o_pin_oe,
    input  wire ccp_src_type             i_src,
    input  wire logic [15:0]             i_t16_count,
    output logic                         o_t16_reset,
    input  wire ccp_tb_type [NUM_TB-1:0] i_tb,
    output logic                         o_ccp_out,
    output logic                         o_event_flag
);

    // The timebase select field is two bits wide, so at most four timers
    if (NUM_TB < 1 || NUM_TB > 4) begin : g_num_tb_check
        $error("NUM_TB must lie between 1 and 4");
    end

    // Registers
    logic [7:0] ctrl_q;
    logic [7:0] val_lo_q;
    logic [7:0] val_hi_q;
    logic [2:0] capsel_q;
    logic [1:0] tbsel_q;
    logic       flag_q;
    logic [7:0] rdata_q;
    logic       pin_meta_q;
    logic       pin_sync_q;
    logic       src_prev_q;
    logic [3:0] psc_q;
    logic       out_q;
    logic       eq_prev_q;
    logic       t16_rst_q;
    logic [9:0] duty_q;
    // Decoded control and datapath nets
    logic       en;
    logic [3:0] mode;
    logic       fmt;
    logic       cap_mode;
    logic       pwm_mode;
    logic       cmp_mode;
    logic       src;
    logic       rise;
    logic       fall;
    logic       cap_evt;
    logic       eq_now;
    logic       cmp_hit;
    logic       restart;
    logic [9:0] duty_buf;
    logic [9:0] timebase;
    ccp_tb_type tb_sel;

    // Write strobe decode for one register offset
    function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] off, input logic w);
        wr_hit = w && (a == off);
    endfunction

    // Mode decode; every code 11xx is PWM, so those codes never compare
    assign en       = ctrl_q[CCP_CTRL_EN_BIT];
    assign mode     = ctrl_q[3:0];
    assign fmt      = ctrl_q[CCP_CTRL_FMT_BIT];
    assign pwm_mode = en && (mode[3:2] == CCP_M_PWM_TOP);
    assign cap_mode = en && (mode >= CCP_M_CAP_EDGE) && (mode <= CCP_M_CAP_RISE16);
    assign cmp_mode = en && !pwm_mode && !cap_mode && (mode != CCP_M_OFF);

    // Control registers written by software
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_q   <= CCP_CTRL_RST;
            capsel_q <= CCP_CAPSEL_RST;
            tbsel_q  <= CCP_TBSEL_RST;
        end else if (i_clk_en) begin
            if (wr_hit(i_addr, CCP_OFF_CTRL, i_wr)) begin
                ctrl_q <= i_wdata;
            end
            if (wr_hit(i_addr, CCP_OFF_CAPSEL, i_wr)) begin
                capsel_q <= i_wdata[2:0];
            end
            if (wr_hit(i_addr, CCP_OFF_TBSEL, i_wr)) begin
                tbsel_q <= i_wdata[1:0];
            end
        end
    end

    // Value pair: capture loads it, software writes it; capture wins a clash
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            val_lo_q <= CCP_VAL_RST;
            val_hi_q <= CCP_VAL_RST;
        end else if (i_clk_en) begin
            if (cap_evt) begin
                val_lo_q <= i_t16_count[7:0];
                val_hi_q <= i_t16_count[15:8];
            end else begin
                if (wr_hit(i_addr, CCP_OFF_VAL_LO, i_wr)) begin
                    val_lo_q <= i_wdata;
                end
                if (wr_hit(i_addr, CCP_OFF_VAL_HI, i_wr)) begin
                    val_hi_q <= i_wdata;
                end
            end
        end
    end

    // Event flag; a set in the clearing cycle wins so no event is lost
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            flag_q <= 1'b0;
        end else if (i_clk_en) begin
            if (cap_evt || cmp_hit) begin
                flag_q <= 1'b1;
            end else if (wr_hit(i_addr, CCP_OFF_STATUS, i_wr) && i_wdata[CCP_STAT_FLAG_BIT]) begin
                flag_q <= 1'b0;
            end
        end
    end

    // Read data, valid in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_q <= 8'h00;
        end else if (i_clk_en) begin
            rdata_q <= 8'h00;
            if (i_rd) begin
                case (i_addr)
                    CCP_OFF_CTRL: begin
                        rdata_q <= ctrl_q;
                        rdata_q[CCP_CTRL_OUT_BIT] <= out_q;
                    end
                    CCP_OFF_VAL_LO: rdata_q <= val_lo_q;
                    CCP_OFF_VAL_HI: rdata_q <= val_hi_q;
                    CCP_OFF_CAPSEL: rdata_q <= {5'h00, capsel_q};
                    CCP_OFF_TBSEL:  rdata_q <= {6'h00, tbsel_q};
                    CCP_OFF_STATUS: rdata_q <= {7'h00, flag_q};
                    default:        rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // Pin is asynchronous to the clock, so two flip-flops first
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else if (i_clk_en) begin
            pin_meta_q <= i_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Capture source mux; reserved codes give a quiet low input
    always_comb begin
        case (capsel_q)
            CCP_SRC_PIN:  src = pin_sync_q;
            CCP_SRC_CMP1: src = i_src.cmp_one_synced;
            CCP_SRC_CMP2: src = i_src.cmp_two_synced;
            CCP_SRC_IOC:  src = i_src.pin_change_trigger;
            CCP_SRC_LC1:  src = i_src.logic_cell_one_out;
            CCP_SRC_LC2:  src = i_src.logic_cell_two_out;
            default:      src = 1'b0;
        endcase
    end

    // Edge detector on the chosen source
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            src_prev_q <= 1'b0;
        end else if (i_clk_en) begin
            src_prev_q <= src;
        end
    end

    // Source edges; switching the select can itself look like an edge
    assign rise = src && !src_prev_q;
    assign fall = !src && src_prev_q;

    // Rising-edge prescaler; a switch between prescale modes keeps the count
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            psc_q <= CCP_PSC_RST;
        end else if (i_clk_en) begin
            if (!cap_mode) begin
                psc_q <= CCP_PSC_RST;
            end else if (rise) begin
                psc_q <= psc_q + 4'h1;
            end
        end
    end

    // Capture event decode; runs in Sleep as long as the clock does
    always_comb begin
        cap_evt = 1'b0;
        if (cap_mode) begin
            case (mode)
                CCP_M_CAP_EDGE:   cap_evt = rise || fall;
                CCP_M_CAP_FALL:   cap_evt = fall;
                CCP_M_CAP_RISE:   cap_evt = rise;
                CCP_M_CAP_RISE4:  cap_evt = rise && (psc_q[1:0] == CCP_PSC_LAST4[1:0]);
                CCP_M_CAP_RISE16: cap_evt = rise && (psc_q == CCP_PSC_LAST16);
                default:          cap_evt = 1'b0;
            endcase
        end
    end

    // Compare acts on the first cycle of equality, since the timer ticks slower
    assign eq_now  = cmp_mode && !i_sleep && ({val_hi_q, val_lo_q} == i_t16_count);
    assign cmp_hit = eq_now && !eq_prev_q;

    // Equality history; the timer reset request leaves registered, one cycle long
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            eq_prev_q <= 1'b0;
            t16_rst_q <= 1'b0;
        end else if (i_clk_en) begin
            eq_prev_q <= eq_now;
            t16_rst_q <= cmp_hit && ((mode == CCP_M_TOG_CLR) || (mode == CCP_M_PULSE_CLR));
        end
    end

    // PWM time base from the selected period timer
    assign tb_sel   = (tbsel_q < NUM_TB) ? i_tb[tbsel_q] : '0;
    assign timebase = {tb_sel.count, tb_sel.low_bits};
    assign restart  = pwm_mode && tb_sel.inc && (tb_sel.count == tb_sel.limit);
    assign duty_buf = fmt ? {val_hi_q, val_lo_q[7:6]}
                          : {val_hi_q[1:0], val_lo_q};

    // Duty latch is double buffered, loaded only at period restart
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            duty_q <= CCP_DUTY_RST;
        end else if (i_clk_en && restart) begin
            duty_q <= duty_buf;
        end
    end

    // Module output shared by all modes
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            out_q <= 1'b0;
        end else if (i_clk_en) begin
            if (!en) begin
                out_q <= 1'b0;
            end else if (cap_mode) begin
                out_q <= cap_evt;
            end else if (pwm_mode) begin
                // Restart wins over a duty match in the same cycle
                if (restart) begin
                    out_q <= (duty_buf != CCP_DUTY_RST);
                end else if (timebase == duty_q) begin
                    out_q <= 1'b0;
                end
            end else if (cmp_mode) begin
                case (mode)
                    CCP_M_TOG_CLR, CCP_M_TOG: begin
                        if (cmp_hit) begin
                            out_q <= !out_q;
                        end
                    end
                    CCP_M_SET: begin
                        if (cmp_hit) begin
                            out_q <= 1'b1;
                        end
                    end
                    CCP_M_CLR: begin
                        if (cmp_hit) begin
                            out_q <= 1'b0;
                        end
                    end
                    CCP_M_FLAG, CCP_M_PULSE_CLR: out_q <= eq_now;
                    default: out_q <= out_q;
                endcase
            end
        end
    end

    // Pin drive; the flag-only mode and a zeroed control register release it
    assign o_pin_oe = en && ctrl_q[CCP_CTRL_OE_BIT]
                   && (mode != CCP_M_FLAG)
                   && !(cap_mode && (capsel_q == CCP_SRC_PIN));
    assign o_pin_out    = out_q;
    assign o_ccp_out    = out_q;
    assign o_event_flag = flag_q;
    assign o_t16_reset  = t16_rst_q;
    assign o_rdata      = rdata_q;

    // Checks on the behaviour above
    cap_pulse_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && cap_mode && !cap_evt && out_q) |=> !out_q)
        else $error("capture pulse longer than one clock");

    cap_value_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && cap_evt) |=> ({val_hi_q, val_lo_q} == $past(i_t16_count)))
        else $error("capture did not load timer count");

    psc_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && !cap_mode) |=> (psc_q == CCP_PSC_RST))
        else $error("prescaler not cleared outside capture");

    flag_set_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && (cap_evt || cmp_hit)) |=> flag_q)
        else $error("event flag not set on event");

    flag_only_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (mode == CCP_M_FLAG) |-> !o_pin_oe)
        else $error("flag-only mode drives pin");

    cap_pin_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (cap_mode && (capsel_q == CCP_SRC_PIN)) |-> !o_pin_oe)
        else $error("pin driven while it is capture input");

    cmp_toggle_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && cmp_hit && ((mode == CCP_M_TOG) || (mode == CCP_M_TOG_CLR)))
        |=> (out_q != $past(out_q)))
        else $error("toggle mode did not invert output");

    ctrl_off_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (ctrl_q == CCP_CTRL_RST) |-> !o_pin_oe)
        else $error("pin held with control register zero");

    pwm_low_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && pwm_mode && !restart && (timebase == duty_q)) |=> !out_q)
        else $error("pwm output not cleared at duty match");

    cmp_set_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && cmp_hit && (mode == CCP_M_SET)) |=> out_q ##1 (out_q || !en))
        else $error("set mode did not drive output high");

endmodule

// [tb/ccp_far_model.sv]
// Far-side model: sixteen-bit timer and period timers feeding the CCP unit
`timescale 1ns/1ns

module ccp_far_model
    import ccp_pkg::*;
#(
    parameter int NUM_TB = 3
) (
    input  wire logic               i_clock,
    input  wire logic               i_sys_rst,
    input  wire logic               i_t16_reset,
    output logic       [15:0]       o_t16_count,
    output ccp_tb_type [NUM_TB-1:0] o_tb
);
    logic [1:0] phase_q;

    // Instruction clock phase, also the two low bits of every time base
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // Steps once per instruction clock, never at the full system rate
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_t16_count <= 16'h0000;
        end else if (i_t16_reset) begin
            o_t16_count <= 16'h0000;
        end else if (phase_q == 2'h3) begin
            o_t16_count <= o_t16_count + 16'h0001;
        end
    end

    // Auto-reload timers with small limits so PWM periods stay short
    for (genvar g = 0; g < NUM_TB; g++) begin : g_tmr
        logic [7:0] cnt_q;
        logic [7:0] lim;
        assign lim = 8'h03 + 8'(2 * g);
        always_ff @(posedge i_clock or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                cnt_q <= 8'h00;
            end else if (phase_q == 2'h3) begin
                cnt_q <= (cnt_q == lim) ? 8'h00 : cnt_q + 8'h01;
            end
        end
        assign o_tb[g] = {cnt_q, lim, phase_q, phase_q == 2'h3};
    end
endmodule

// [tb/tb.sv]
// Self-checking testbench for the CCP unit
`timescale 1ns/1ns

module tb;
    import ccp_pkg::*;

    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic [2:0]          addr = 3'h0;
    logic [7:0]          wdata = 8'h00;
    logic                wr_s = 1'b0;
    logic                rd_s = 1'b0;
    logic                sleep = 1'b0;
    logic                pin = 1'b0;
    logic [4:0]          src = 5'h00;
    logic [7:0]          rdata;
    logic                pin_out;
    logic                pin_oe;
    logic [15:0]         t16;
    logic                t16_rst;
    ccp_tb_type [2:0]    tbv;
    logic                ccp_out;
    logic                flag;
    int                  mismatches = 0;
    int                  checked = 0;
    int                  highs = 0;
    int                  rsts = 0;
    int                  cyc = 0;

    ccp_unit #(.NUM_TB(3)) dut_u (
        .i_clock(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
        .i_sleep(sleep), .i_pin(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
        .i_src(src), .i_t16_count(t16), .o_t16_reset(t16_rst), .i_tb(tbv),
        .o_ccp_out(ccp_out), .o_event_flag(flag));

    ccp_far_model #(.NUM_TB(3)) far_u (
        .i_clock(clk), .i_sys_rst(rst), .i_t16_reset(t16_rst),
        .o_t16_count(t16), .o_tb(tbv));

    always #25 clk = ~clk;

    // Pulse counters and a hang guard well above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ccp_out === 1'b1) highs <= highs + 1;
        if (t16_rst === 1'b1) rsts <= rsts + 1;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(n, rdata, e);
    endtask

    // Pin held at least four cycles per level so its synchroniser sees every edge
    task automatic tog(input logic [5:0] m, input int n);
        repeat (n) begin
            @(posedge clk);
            {pin, src} <= m;
            repeat (4) @(posedge clk);
            {pin, src} <= 6'h00;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask

    task automatic t_regs;
        for (int a = 0; a < 7; a++) rd(3'(a), 8'h00, "reset_value");
        wr(CCP_OFF_VAL_LO, 8'h5A);
        wr(CCP_OFF_VAL_HI, 8'hC3);
        wr(CCP_OFF_CAPSEL, 8'hFF);
        wr(CCP_OFF_TBSEL, 8'hFF);
        wr(3'h6, 8'hFF);
        wr(CCP_OFF_CTRL, 8'h3F);
        rd(CCP_OFF_VAL_LO, 8'h5A, "val_lo");
        rd(CCP_OFF_VAL_HI, 8'hC3, "val_hi");
        rd(CCP_OFF_CAPSEL, 8'h07, "capsel");
        rd(CCP_OFF_TBSEL, 8'h03, "tbsel");
        rd(3'h6, 8'h00, "unmapped");
        rd(CCP_OFF_CTRL, 8'h1F, "ctrl_out_ro");
        $display("test regs done");
    endtask

    task automatic t_cap;
        logic [15:0] e;
        sleep <= 1'b1;
        for (int s = 0; s < 6; s++) begin
            wr(CCP_OFF_CAPSEL, 8'(s));
            wr(CCP_OFF_CTRL, 8'hC0 | 8'(CCP_M_CAP_RISE));
            wr(CCP_OFF_STATUS, 8'h01);
            @(posedge clk);
            #1 chk("cap_pin_oe", pin_oe, s != 0);
            @(posedge clk);
            if (s == 0) pin <= 1'b1;
            else src <= 5'h10 >> (s - 1);
            repeat (s == 0 ? 3 : 1) @(negedge clk);
            e = t16;
            @(posedge clk);
            #1 chk("cap_out", ccp_out, 1'b1);
            chk("cap_flag", flag, 1'b1);
            @(posedge clk);
            #1 chk("cap_out_end", ccp_out, 1'b0);
            rd(CCP_OFF_VAL_LO, e[7:0], "cap_lo");
            rd(CCP_OFF_VAL_HI, e[15:8], "cap_hi");
            @(posedge clk);
            pin <= 1'b0;
            src <= 5'h00;
        end
        // Reserved selects must never produce a capture
        wr(CCP_OFF_CAPSEL, 8'h06);
        highs = 0;
        tog(6'h3F, 2);
        chk("reserved_src", highs, 0);
        sleep <= 1'b0;
        $display("test capture done");
    endtask

    task automatic t_psc;
        int ex [5] = '{32, 16, 16, 4, 1};
        wr(CCP_OFF_CAPSEL, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(CCP_OFF_CTRL, 8'h80 | 8'(4'h3 + i));
            highs = 0;
            tog(6'h10, 16);
            chk("edge_count", highs, ex[i]);
            wr(CCP_OFF_CTRL, 8'h00);
        end
        // Disabling drops the partial count; a plain mode change keeps it
        wr(CCP_OFF_CTRL, 8'h86);
        tog(6'h10, 2);
        wr(CCP_OFF_CTRL, 8'h00);
        wr(CCP_OFF_CTRL, 8'h86);
        highs = 0;
        tog(6'h10, 3);
        chk("psc_cleared", highs, 0);
        tog(6'h10, 1);
        chk("psc_fourth", highs, 1);
        wr(CCP_OFF_CTRL, 8'h00);
        wr(CCP_OFF_CTRL, 8'h87);
        tog(6'h10, 3);
        wr(CCP_OFF_CTRL, 8'h86);
        highs = 0;
        tog(6'h10, 1);
        chk("psc_kept", highs, 1);
        wr(CCP_OFF_CTRL, 8'h00);
        $display("test prescaler done");
    endtask

    task automatic cmp(input logic [3:0] m, input logic s, input logic eo, ef, eoe,
                       input int er, input int eh);
        logic [15:0] t;
        wr(CCP_OFF_CTRL, 8'h00);
        wr(CCP_OFF_STATUS, 8'h01);
        @(negedge clk);
        t = t16 + 16'h0014;
        wr(CCP_OFF_VAL_LO, t[7:0]);
        wr(CCP_OFF_VAL_HI, t[15:8]);
        sleep <= s;
        wr(CCP_OFF_CTRL, 8'hC0 | 8'(m));
        highs = 0;
        rsts = 0;
        repeat (120) @(posedge clk);
        #1 chk("cmp_out", ccp_out, eo);
        chk("cmp_pin_out", pin_out, eo);
        chk("cmp_flag", flag, ef);
        chk("cmp_t16_reset", rsts, er);
        chk("cmp_pin_oe", pin_oe, eoe);
        if (eh >= 0) chk("cmp_width", highs, eh);
        @(posedge clk);
        sleep <= 1'b0;
    endtask

    task automatic t_cmp;
        cmp(CCP_M_TOG_CLR, 1'b0, 1'b1, 1'b1, 1'b1, 1, -1);
        cmp(CCP_M_TOG, 1'b0, 1'b1, 1'b1, 1'b1, 0, -1);
        cmp(CCP_M_SET, 1'b0, 1'b1, 1'b1, 1'b1, 0, -1);
        cmp(CCP_M_CLR, 1'b0, 1'b0, 1'b1, 1'b1, 0, 0);
        cmp(CCP_M_FLAG, 1'b0, 1'b0, 1'b1, 1'b0, 0, 4);
        cmp(CCP_M_PULSE_CLR, 1'b0, 1'b0, 1'b1, 1'b1, 1, 2);
        cmp(CCP_M_SET, 1'b1, 1'b0, 1'b0, 1'b1, 0, 0);
        $display("test compare done");
    endtask

    // High time per period is duty plus the one-cycle clear latency, none at zero duty, the whole period once duty reaches it
    task automatic pwm(input int s, input logic f, input logic [9:0] d);
        int p;
        int eh;
        p = 16 + 8 * s;
        eh = (d == 10'h000) ? 0 : (int'(d) >= p) ? 3 * p : 3 * (int'(d) + 1);
        wr(CCP_OFF_TBSEL, 8'(s));
        wr(CCP_OFF_VAL_LO, f ? {d[1:0], 6'h00} : d[7:0]);
        wr(CCP_OFF_VAL_HI, f ? d[9:2] : {6'h00, d[9:8]});
        wr(CCP_OFF_CTRL, f ? 8'h9C : 8'h8C);
        // Pin driver only after the selected period timer has wrapped once
        @(posedge clk);
        while (!(tbv[s].inc && (tbv[s].count == tbv[s].limit))) @(posedge clk);
        wr(CCP_OFF_CTRL, f ? 8'hDC : 8'hCC);
        repeat (64) @(posedge clk);
        @(negedge clk);
        highs = 0;
        repeat (3 * p) @(posedge clk);
        #1 chk("pwm_high", highs, eh);
    endtask

    task automatic t_pwm;
        pwm(0, 1'b0, 10'h005);
        pwm(1, 1'b1, 10'h00A);
        pwm(2, 1'b0, 10'h000);
        pwm(2, 1'b1, 10'h028);
        wr(CCP_OFF_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk("release_oe", pin_oe, 1'b0);
        chk("release_out", ccp_out, 1'b0);
        $display("test pwm done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_cap();
        t_psc();
        t_cmp();
        t_pwm();
        finish_test();
    end
endmodule
